// ### led_bus_reset.sv
// Purpose: Bus address recognition, reset handling and group brightness timing.
// Assumes: mclk drives the bus side; osc_clk is the free-running oscillator.
// Notes:   Bus pins are open drain; the pin level is resolved outside.
// What this block does
// - Sub-addresses reset D2h D4h D8h, disabled
// - Sub-address acknowledged only once enabled
// - Bits 7:5 fixed 110, bit 0 zero
// - Enabled sub-address accepted for reads, writes
// - Group call field defaults 1000, enable gates
// - Group call programmable, works reads and writes
// - Power-on reset restores defaults, outputs off
// - Low reset pin holds defaults until high
// - Acknowledge reset address only as write
// - Reset address with read gets no acknowledge
// - First key byte must be A5h
// - Second key byte must be 5Ah
// - Bytes after two keys never acknowledged
// - Stop after keys restores power-up state
// - Wrong handshake never resets registers
// - Each output has own 256-step fast pulse
// - Dimming superimposes slow group duty signal
// - Blinking uses programmable group period
// - Individual pulse quantum is 40 ns
// - Group dimming step is 20.48 us
// - Each group step passes two individual pulses
// - Select bit chooses dimming or blinking
// - Blink period is period value plus one over 24
// - Group signal affects only state 11 outputs
`include "led_drv_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module led_bus_reset #(
  parameter int BLINK_STEP_CYC = `BLINK_STEP_CYC
) (
  // Clocks and resets.
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic         osc_clk,
  input  wire logic         rst_n_pin,
  // Bus pins.
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe,
  input  wire logic [6:0]   hw_address,
  // Mode bits held by the mode register.
  input  wire logic [2:0]   sub_address_enable,
  input  wire logic         group_call_enable,
  input  wire logic         dim_or_blink_select,
  // Brightness settings held by the register map.
  input  wire logic [127:0] individual_duty,
  input  wire logic [31:0]  output_state_field,
  input  wire logic [7:0]   group_duty,
  input  wire logic [7:0]   group_period,
  // Register access from the byte protocol.
  input  wire logic [7:0]   reg_addr,
  input  wire logic         reg_write,
  input  wire logic [7:0]   reg_wdata,
  output logic [7:0]        reg_rdata,
  // Byte stream to and from the byte protocol.
  output logic              addr_hit,
  output logic              addr_read,
  output logic [7:0]        rx_byte,
  output logic              rx_valid,
  output logic              rx_first,
  input  wire logic [7:0]   read_byte,
  output logic              read_next,
  output logic              bus_reset_done,
  // LED drive, high means the channel sinks current.
  output logic [15:0]       led_on
);

  // Default values of the four address registers, group call last.
  localparam logic [7:0] ADDR_DEFAULT [0:3] = '{`SUB_ONE_RESET, `SUB_TWO_RESET,
                                                `SUB_THREE_RESET, `GROUP_CALL_RESET};

  // Pin synchronisers; the first stage feeds only the second.
  logic       scl_s1, scl_s2, scl_d;   // Clock line stages.
  logic       sda_s1, sda_s2, sda_d;   // Data line stages.
  logic       rstn_s1, rstn_s2;        // Reset pin stages.
  logic [6:0] hwa_s1, hwa_s2;          // Hardware address stages.

  // Bus receiver state.
  led_drv_pkg::bus_state_type   st;        // Receiver state.
  led_drv_pkg::reset_phase_type phase;     // Reset handshake progress.
  logic [3:0]  bit_cnt;                    // Clock rises within the byte.
  logic [7:0]  shreg;                      // Received byte.
  logic [7:0]  tx;                         // Byte being sent.
  logic        is_addr;                    // Current byte is the address.
  logic        first_data;                 // Next data byte is the first.
  logic        master_nack;                // Master refused the last byte.
  logic        soft_pulse;                 // Handshake completed on stop.

  // Address registers, writable bits only.
  logic [3:0]  addr_bits [0:3];
  logic [7:0]  addr_val  [0:3];
  logic [3:0]  addr_en;
  logic [3:0]  addr_match;

  // Events decoded from the synchronised pins.
  logic rise_ev, fall_ev, start_ev, stop_ev, decide;
  logic regs_reset, hw_match, reset_call, addr_accept, data_accept;

  // Open drain: the pin is only ever pulled low.
  assign sda_out = 1'b0;

  // Pin synchronisers.
  always_ff @(posedge mclk) begin : pin_sync
    scl_s1  <= scl_in;
    scl_s2  <= scl_s1;
    scl_d   <= scl_s2;
    sda_s1  <= sda_in;
    sda_s2  <= sda_s1;
    sda_d   <= sda_s2;
    rstn_s1 <= rst_n_pin;
    rstn_s2 <= rstn_s1;
    hwa_s1  <= hw_address;
    hwa_s2  <= hwa_s1;
  end

  // Bus events and the reset that returns the address registers, bus state and oscillator side to defaults.
  assign rise_ev    = scl_s2 & ~scl_d;
  assign fall_ev    = ~scl_s2 & scl_d;
  assign start_ev   = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_ev    = scl_s2 & scl_d & ~sda_d & sda_s2;
  assign regs_reset = srst | ~rstn_s2 | soft_pulse;
  assign decide     = (st == led_drv_pkg::BUS_RECV) && fall_ev && (bit_cnt == `BITS_PER_BYTE);
  assign addr_en    = {group_call_enable, sub_address_enable};

  // Each address register: fixed bits around the writable field.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_addr
      always_ff @(posedge mclk) begin
        if (regs_reset) begin
          addr_bits[gi] <= ADDR_DEFAULT[gi][4:1];
        end else if (reg_write && (reg_addr == (`OFS_SUB_ONE + 8'(gi)))) begin
          addr_bits[gi] <= reg_wdata[4:1];
        end
      end
      assign addr_val[gi]   = {`ADDR_FIXED_HI, addr_bits[gi], `ADDR_FIXED_LO};
      assign addr_match[gi] = addr_en[gi] && (shreg[7:1] == addr_val[gi][7:1]);
    end
  endgenerate

  // Register read port; unmapped offsets read zero.
  always_ff @(posedge mclk) begin : reg_read
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr >= `OFS_SUB_ONE && reg_addr <= `OFS_GROUP_CALL) begin
      reg_rdata <= addr_val[reg_addr[1:0]];
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Address and key decisions.
  assign hw_match    = (shreg[7:1] == hwa_s2);
  assign reset_call  = (shreg[7:1] == `RESET_CALL_ADDR);
  // The reset address only answers a write; any direction for the others.
  assign addr_accept = reset_call ? ~shreg[0] : (hw_match || (|addr_match));
  always_comb begin : key_check
    case (phase)
      led_drv_pkg::PHASE_NONE: data_accept = 1'b1;
      led_drv_pkg::PHASE_KEY1: data_accept = (shreg == `KEY_ONE);
      led_drv_pkg::PHASE_KEY2: data_accept = (shreg == `KEY_TWO);
      default:                 data_accept = 1'b0;
    endcase
  end

  // Bus receiver and transmitter.
  always_ff @(posedge mclk) begin : bus_fsm
    rx_valid  <= 1'b0;
    read_next <= 1'b0;
    addr_hit  <= 1'b0;
    if (regs_reset) begin
      st          <= led_drv_pkg::BUS_IDLE;
      phase       <= led_drv_pkg::PHASE_NONE;
      bit_cnt     <= 4'h0;
      shreg       <= 8'h00;
      tx          <= 8'h00;
      is_addr     <= 1'b0;
      first_data  <= 1'b0;
      master_nack <= 1'b0;
      addr_read   <= 1'b0;
      rx_byte     <= 8'h00;
      rx_first    <= 1'b0;
      sda_oe      <= 1'b0;
      soft_pulse  <= 1'b0;
    end else if (start_ev) begin
      // A start or repeated start always opens a fresh address byte.
      st         <= led_drv_pkg::BUS_RECV;
      phase      <= led_drv_pkg::PHASE_NONE;
      bit_cnt    <= 4'h0;
      is_addr    <= 1'b1;
      sda_oe     <= 1'b0;
      soft_pulse <= 1'b0;
    end else if (stop_ev) begin
      // Only a completed handshake resets; anything short of it is dropped.
      st         <= led_drv_pkg::BUS_IDLE;
      sda_oe     <= 1'b0;
      soft_pulse <= (phase == led_drv_pkg::PHASE_DONE);
      phase      <= led_drv_pkg::PHASE_NONE;
    end else begin
      soft_pulse <= 1'b0;
      case (st)
        led_drv_pkg::BUS_RECV: begin
          if (rise_ev) begin
            if (bit_cnt < `BITS_PER_BYTE) begin
              shreg <= {shreg[6:0], sda_s2};
            end
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (decide && is_addr) begin
            // Address byte: drive the acknowledge only on a match.
            sda_oe     <= addr_accept;
            addr_read  <= shreg[0];
            addr_hit   <= addr_accept && !reset_call;
            first_data <= 1'b1;
            if (reset_call && addr_accept) begin
              phase <= led_drv_pkg::PHASE_KEY1;
            end
            if (!addr_accept) begin
              st <= led_drv_pkg::BUS_IGNORE;
            end
          end else if (decide) begin
            // Data byte: keys are checked, ordinary bytes pass on.
            sda_oe     <= data_accept;
            first_data <= 1'b0;
            rx_byte    <= shreg;
            rx_first   <= first_data;
            rx_valid   <= data_accept && (phase == led_drv_pkg::PHASE_NONE);
            if (!data_accept) begin
              st    <= led_drv_pkg::BUS_IGNORE;
              phase <= led_drv_pkg::PHASE_NONE;
            end else if (phase == led_drv_pkg::PHASE_KEY1) begin
              phase <= led_drv_pkg::PHASE_KEY2;
            end else if (phase == led_drv_pkg::PHASE_KEY2) begin
              phase <= led_drv_pkg::PHASE_DONE;
            end
          end else if (fall_ev && bit_cnt == `ACK_SLOT) begin
            // End of the acknowledge slot: release, or start sending.
            bit_cnt <= 4'h0;
            is_addr <= 1'b0;
            if (is_addr && addr_read) begin
              st        <= led_drv_pkg::BUS_SEND;
              tx        <= read_byte;
              sda_oe    <= ~read_byte[7];
              read_next <= 1'b1;
            end else begin
              sda_oe <= 1'b0;
            end
          end
        end
        led_drv_pkg::BUS_SEND: begin
          if (rise_ev) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `BITS_PER_BYTE) begin
              master_nack <= sda_s2;
            end
          end
          if (fall_ev && bit_cnt > 4'h0 && bit_cnt < `BITS_PER_BYTE) begin
            tx     <= {tx[6:0], 1'b0};
            sda_oe <= ~tx[6];
          end else if (fall_ev && bit_cnt == `BITS_PER_BYTE) begin
            sda_oe <= 1'b0;
          end else if (fall_ev && bit_cnt == `ACK_SLOT) begin
            bit_cnt <= 4'h0;
            if (master_nack) begin
              st <= led_drv_pkg::BUS_IGNORE;
            end else begin
              tx        <= read_byte;
              sda_oe    <= ~read_byte[7];
              read_next <= 1'b1;
            end
          end
        end
        default: begin
          // Idle or ignoring: keep off the line until the next start.
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Completion pulse for the registers held outside this block.
  assign bus_reset_done = soft_pulse;

  // Configuration handshake towards the oscillator domain.
  logic         cfg_req;           // Request toggle.
  logic         ack_s1, ack_s2;    // Returned acknowledge stages.
  logic         rst_any;           // Any reset, for the oscillator domain.
  logic [3:0]   rst_hold;          // Cycles left of the stretched reset.
  logic [127:0] cfg_duty;          // Held individual duties.
  logic [31:0]  cfg_state;         // Held output states.
  logic [7:0]   cfg_gduty;         // Held group duty.
  logic [7:0]   cfg_gper;          // Held group period.
  logic         cfg_blink;         // Held select bit.
  logic         osc_ack;           // Acknowledge toggle from the oscillator side.

  // A one-cycle reset is far shorter than an oscillator period, so it is
  // held long enough for the oscillator side to sample it at least twice.
  always_ff @(posedge mclk) begin : rst_stretch
    if (regs_reset) begin
      rst_hold <= `RST_STRETCH;
    end else if (rst_hold != 4'h0) begin
      rst_hold <= rst_hold - 4'h1;
    end
  end

  // The held words change only while no request is outstanding.
  always_ff @(posedge mclk) begin : cfg_send
    ack_s1  <= osc_ack;
    ack_s2  <= ack_s1;
    rst_any <= regs_reset || (rst_hold != 4'h0);
    if (srst) begin
      cfg_req   <= 1'b0;
      cfg_duty  <= 128'h0;
      cfg_state <= 32'h0;
      cfg_gduty <= `GROUP_DUTY_RESET;
      cfg_gper  <= `GROUP_PERIOD_RESET;
      cfg_blink <= 1'b0;
    end else if (ack_s2 == cfg_req) begin
      cfg_req   <= ~cfg_req;
      cfg_duty  <= individual_duty;
      cfg_state <= output_state_field;
      cfg_gduty <= group_duty;
      cfg_gper  <= group_period;
      cfg_blink <= dim_or_blink_select;
    end
  end

  // Oscillator domain.
  logic         rst_o1, osc_rst;           // Reset stages.
  logic         req_o1, req_o2, req_o3;    // Request stages.
  logic [127:0] o_duty;
  logic [31:0]  o_state;
  logic [7:0]   o_gduty, o_gper;
  logic         o_blink;
  logic [16:0]  dim_cnt;                   // Individual and group dimming counter.
  logic [12:0]  pre_cnt;                   // Blink step prescaler.
  logic [7:0]   rep_cnt;                   // Repeats of a blink step.
  logic [7:0]   blink_step;                // Position within the blink period.
  logic         grp_on;                    // Group window open.

  // Capture the held words when a new request arrives.
  always_ff @(posedge osc_clk) begin : cfg_recv
    rst_o1  <= rst_any;
    osc_rst <= rst_o1;
    req_o1  <= cfg_req;
    req_o2  <= req_o1;
    req_o3  <= req_o2;
    if (osc_rst) begin
      // Echo the request so the toggle handshake never deadlocks across a reset.
      osc_ack <= req_o2;
      o_duty  <= 128'h0;
      o_state <= 32'h0;
      o_gduty <= `GROUP_DUTY_RESET;
      o_gper  <= `GROUP_PERIOD_RESET;
      o_blink <= 1'b0;
    end else if (req_o2 != req_o3) begin
      osc_ack <= req_o2;
      o_duty  <= cfg_duty;
      o_state <= cfg_state;
      o_gduty <= cfg_gduty;
      o_gper  <= cfg_gper;
      o_blink <= cfg_blink;
    end
  end

  // One count per 40 ns quantum; bit 8 pairs two individual periods per group step.
  always_ff @(posedge osc_clk) begin : dim_timer
    if (osc_rst) begin
      dim_cnt <= 17'h0;
    end else begin
      dim_cnt <= dim_cnt + 17'h1;
    end
  end

  // Blink steps last (period + 1) prescaler spans, 256 steps a period.
  always_ff @(posedge osc_clk) begin : blink_timer
    if (osc_rst) begin
      pre_cnt    <= 13'h0;
      rep_cnt    <= 8'h00;
      blink_step <= 8'h00;
    end else if (pre_cnt == 13'(BLINK_STEP_CYC - 1)) begin
      pre_cnt <= 13'h0;
      if (rep_cnt == o_gper) begin
        rep_cnt    <= 8'h00;
        blink_step <= blink_step + 8'h01;
      end else begin
        rep_cnt <= rep_cnt + 8'h01;
      end
    end else begin
      pre_cnt <= pre_cnt + 13'h1;
    end
  end

  // Group window from the selected source.
  assign grp_on = o_blink ? (blink_step < o_gduty) : (dim_cnt[16:9] < o_gduty);

  // Per-channel output stage.
  generate
    for (gi = 0; gi < 16; gi++) begin : g_led
      always_ff @(posedge osc_clk) begin
        if (osc_rst) begin
          led_on[gi] <= 1'b0;
        end else begin
          case (o_state[2*gi +: 2])
            `STATE_ON:         led_on[gi] <= 1'b1;
            `STATE_INDIVIDUAL: led_on[gi] <= dim_cnt[7:0] < o_duty[8*gi +: 8];
            `STATE_GROUP:      led_on[gi] <= (dim_cnt[7:0] < o_duty[8*gi +: 8]) && grp_on;
            default:           led_on[gi] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // Checks on the bus side, then one on the oscillator side.
  chk_soft_reset_defaults: assert property (@(posedge mclk) disable iff (srst)
    soft_pulse |=> addr_val[0] == `SUB_ONE_RESET && addr_val[1] == `SUB_TWO_RESET
      && addr_val[2] == `SUB_THREE_RESET && addr_val[3] == `GROUP_CALL_RESET)
    else $error("Address registers not at defaults after bus reset.");

  chk_disabled_sub_nack: assert property (@(posedge mclk) disable iff (srst)
    (decide && is_addr && !hw_match && !reset_call && !(|addr_match)) |=> !sda_oe)
    else $error("Acknowledged an address that is not enabled.");

  chk_fixed_bits_read: assert property (@(posedge mclk) disable iff (srst)
    ($past(reg_addr) >= `OFS_SUB_ONE && $past(reg_addr) <= `OFS_GROUP_CALL)
      |-> reg_rdata[7:5] == `ADDR_FIXED_HI && reg_rdata[0] == `ADDR_FIXED_LO)
    else $error("Fixed address bits read wrong.");

  chk_sub_any_dir: assert property (@(posedge mclk) disable iff (srst)
    (decide && is_addr && !reset_call && |addr_match) |=> sda_oe ##0 addr_hit)
    else $error("Enabled address not acknowledged.");

  chk_reset_read_nack: assert property (@(posedge mclk) disable iff (srst)
    (decide && is_addr && reset_call && shreg[0]) |=> !sda_oe && st == led_drv_pkg::BUS_IGNORE)
    else $error("Reset address acknowledged for a read.");

  chk_key_one: assert property (@(posedge mclk) disable iff (srst)
    (decide && !is_addr && phase == led_drv_pkg::PHASE_KEY1)
      |=> sda_oe == ($past(shreg) == `KEY_ONE))
    else $error("First key byte answered wrongly.");

  chk_key_two: assert property (@(posedge mclk) disable iff (srst)
    (decide && !is_addr && phase == led_drv_pkg::PHASE_KEY2)
      |=> sda_oe == ($past(shreg) == `KEY_TWO))
    else $error("Second key byte answered wrongly.");

  chk_extra_byte: assert property (@(posedge mclk) disable iff (srst)
    (decide && !is_addr && phase == led_drv_pkg::PHASE_DONE) |=> !sda_oe ##1 !soft_pulse)
    else $error("Byte after the keys was acknowledged.");

  chk_reset_cause: assert property (@(posedge mclk) disable iff (srst)
    $rose(soft_pulse) |-> $past(stop_ev) && $past(phase) == led_drv_pkg::PHASE_DONE)
    else $error("Bus reset without a full handshake.");

  chk_pin_reset_hold: assert property (@(posedge mclk) disable iff (srst)
    !rstn_s2 [*2] |-> st == led_drv_pkg::BUS_IDLE && !sda_oe && addr_bits[3] == ADDR_DEFAULT[3][4:1])
    else $error("State not held at defaults under the reset pin.");

  chk_off_channel: assert property (@(posedge osc_clk) disable iff (osc_rst)
    ($past(o_state[1:0]) == `STATE_OFF) |-> !led_on[0])
    else $error("Channel lit while its state is off.");

endmodule : led_bus_reset

`default_nettype wire

// ### led_drv_consts.svh
// Purpose: Named constants for the LED driver bus address and reset block.
// Assumes: Included by its bare name from the design file.
// Notes:   Definitions only; no logic lives here.
`ifndef LED_DRV_CONSTS_SVH
`define LED_DRV_CONSTS_SVH

// Register offsets of the address registers.
`define OFS_SUB_ONE       8'h18
`define OFS_SUB_TWO       8'h19
`define OFS_SUB_THREE     8'h1A
`define OFS_GROUP_CALL    8'h1B

// Reset values of the address registers.
`define SUB_ONE_RESET     8'hD2
`define SUB_TWO_RESET     8'hD4
`define SUB_THREE_RESET   8'hD8
`define GROUP_CALL_RESET  8'hD0

// Fixed upper bits and fixed low bit of each address register.
`define ADDR_FIXED_HI     3'h6
`define ADDR_FIXED_LO     1'h0

// Reserved bus reset address and its two key bytes.
`define RESET_CALL_ADDR   7'h6B
`define KEY_ONE           8'hA5
`define KEY_TWO           8'h5A

// Bit counts within one bus byte.
`define BITS_PER_BYTE     4'h8
`define ACK_SLOT          4'h9

// Output state field codes.
`define STATE_OFF         2'h0
`define STATE_ON          2'h1
`define STATE_INDIVIDUAL  2'h2
`define STATE_GROUP       2'h3

// Reset values of the group controls.
`define GROUP_DUTY_RESET  8'hFF
`define GROUP_PERIOD_RESET 8'h00

// Oscillator period, individual quantum and blink step timing.
`define OSC_PERIOD_NS     40
`define QUANTUM_NS        40
`define BLINK_STEP_NS     162760
`define BLINK_STEP_CYC    (`BLINK_STEP_NS / `OSC_PERIOD_NS)

// Bus clock cycles a reset is stretched so the oscillator side sees it twice.
`define RST_STRETCH       4'hF

`endif

// ### led_drv_pkg.sv
// Purpose: Types shared by the LED driver bus address and reset block.
// Assumes: Compiled before the design file.
// Notes:   Holds types only; numbers live in the constants header.
package led_drv_pkg;

  // States of the bus receiver.
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b00,
    BUS_RECV   = 2'b01,
    BUS_SEND   = 2'b10,
    BUS_IGNORE = 2'b11
  } bus_state_type;

  // Progress through the bus reset handshake.
  typedef enum logic [1:0] {
    PHASE_NONE = 2'b00,
    PHASE_KEY1 = 2'b01,
    PHASE_KEY2 = 2'b10,
    PHASE_DONE = 2'b11
  } reset_phase_type;

endpackage : led_drv_pkg

// ### bus_master_model.sv
// Purpose: Bus master model that drives the clock and data lines of the device.
// Assumes: Both lines have pull-ups; the device pulls data low through sda_oe.
// Notes:   Each data bit clock phase lasts 100 ns, far above the receiver filter; the clock stays high 200 ns across a start.
`timescale 1ns/10ps
`default_nettype none

module bus_master_model (
  // Device pull on the data line.
  input  wire logic sda_oe,
  // Resolved bus lines.
  output logic      scl,
  output logic      sda
);
  logic m_low;  // High while the master pulls data low.

  // The line is high unless either party pulls it, as with a pull-up.
  assign sda = !(m_low || (sda_oe === 1'b1));

  // Both lines idle high.
  initial begin
    scl = 1'b1;
    m_low = 1'b0;
  end

  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    m_low = 1'b0;
    #100 scl = 1'b1;
    #100 m_low = 1'b1;
    #100 scl = 1'b0;
  endtask : start

  // Stop: data rises while the clock is high, which ends the reset call.
  task automatic stop();
    m_low = 1'b1;
    #100 scl = 1'b1;
    #100 m_low = 1'b0;
    #100;
  endtask : stop

  // Eight bits MSB first, then an acknowledge slot left released.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      #50 m_low = (i >= 0) ? !tx[i] : 1'b0;
      #50 scl = 1'b1;
      #50 if (i >= 0) rx[i] = sda; else ack = !sda;
      #50 scl = 1'b0;
    end
  endtask : xfer
endmodule : bus_master_model
`default_nettype wire

// ### tb.sv
// Purpose: Self-checking bench for bus address recognition and the reset call.
// Assumes: The master model drives the bus; the oscillator clock runs at 64 ns.
// Notes:   Inputs change at the falling edge of mclk.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module tb;
  logic         mclk = 1'b0, osc_clk = 1'b0, srst = 1'b1, rst_n_pin = 1'b1;
  logic [6:0]   hw;
  logic [2:0]   sub_en;
  logic         gc_en, dob, rw, oe, done, scl, sda, ard, rxf;
  logic [127:0] duty;
  logic [31:0]  osf;
  logic [15:0]  led;
  logic [7:0]   gd, gp, ra, wd, rd, rbyte, rxv, rxb, val, e1, seed;
  logic [3:0]   ak;
  logic [7:0]   dflt [4] = '{8'hD2, 8'hD4, 8'hD8, 8'hD0};
  int           miscompares = 0, n_checks = 0, n_done = 0, cyc = 0;

  always #5 mclk = ~mclk;
  always #32 osc_clk = ~osc_clk;

  // Counts reset-call completions and cuts a hang short.
  always @(posedge mclk) begin
    cyc++;
    if (done === 1'b1) n_done++;
    if (cyc > 30000) begin
      miscompares++;
      final_report();
    end
  end

  led_bus_reset #(.BLINK_STEP_CYC(4)) i_dut (
    .mclk(mclk), .srst(srst), .osc_clk(osc_clk), .rst_n_pin(rst_n_pin),
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(oe), .hw_address(hw),
    .sub_address_enable(sub_en), .group_call_enable(gc_en), .dim_or_blink_select(dob),
    .individual_duty(duty), .output_state_field(osf), .group_duty(gd), .group_period(gp),
    .reg_addr(ra), .reg_write(rw), .reg_wdata(wd), .reg_rdata(rd),
    .addr_hit(), .addr_read(ard), .rx_byte(rxv), .rx_valid(), .rx_first(rxf),
    .read_byte(rbyte), .read_next(), .bus_reset_done(done), .led_on(led));
  bus_master_model i_bus (.sda_oe(oe), .scl(scl), .sda(sda));

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    ra = a;
    wd = d;
    rw = 1'b1;
    @(negedge mclk);
    rw = 1'b0;
  endtask : reg_wr

  task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    ra = a;
    repeat (2) @(negedge mclk);
    `CHK("reg_rdata", e, rd)
  endtask : reg_chk

  // One transaction; ak holds the acknowledge of each byte sent.
  task automatic run(input logic [31:0] b, input int n, input logic [3:0] e);
    logic a;
    ak = 4'h0;
    i_bus.start();
    for (int k = 0; k < n; k++) begin
      i_bus.xfer(b[31-8*k -: 8], rxb, a);
      ak[k] = a;
      if (!a) break;
    end
    i_bus.stop();
    #400;
    @(negedge mclk);
    `CHK("ack", e, ak)
  endtask : run

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  initial begin
    seed = 8'($urandom(69715));
    {rw, ra, wd, sub_en, gc_en} = {20'h0, 1'b1};
    hw = 7'h40 | 7'($urandom % 16);
    duty = {$urandom, $urandom, $urandom, $urandom};
    osf = ($urandom & 32'hFFFF_FFF0) | 32'h1;
    {gd, gp, rbyte, dob} = 25'($urandom);
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    repeat (8) @(negedge mclk);
    for (int i = 0; i < 4; i++) reg_chk(8'h18 + 8'(i), dflt[i]);
    reg_chk(8'h1C, 8'h00);
    run(32'hD211_0000, 2, 4'h0);
    run({hw, 1'b0, 24'h3C0000}, 2, 4'h3);
    run(32'h2000_0000, 2, 4'h0);
    val = 8'($urandom) & 8'hEF;
    e1 = 8'hC0 | (val & 8'h0E);
    reg_wr(8'h18, val);
    reg_chk(8'h18, e1);
    sub_en = 3'h7;
    run({e1, val, 16'h0}, 2, 4'h3);
    `CHK("rx_byte", val, rxv)
    `CHK("rx_first", 1'b1, rxf)
    `CHK("addr_read", 1'b0, ard)
    run({e1 | 8'h01, 24'hFF0000}, 2, 4'h1);
    `CHK("read data", rbyte, rxb)
    `CHK("addr_read", 1'b1, ard)
    run(32'hD844_0000, 2, 4'h3);
    run(32'hD055_0000, 2, 4'h3);
    gc_en = 1'b0;
    run(32'hD055_0000, 2, 4'h0);
    gc_en = 1'b1;
    reg_wr(8'h1B, 8'hFF);
    reg_chk(8'h1B, 8'hDE);
    run(32'hDE66_0000, 2, 4'h3);
    run(32'hDFFF_0000, 2, 4'h1);
    run(32'hD7FF_0000, 2, 4'h0);
    run(32'hD6A4_0000, 2, 4'h1);
    run(32'hD6A5_5B00, 3, 4'h3);
    `CHK("reset count", 0, n_done)
    reg_chk(8'h18, e1);
    run(32'hD6A5_5A00, 3, 4'h7);
    `CHK("reset count", 1, n_done)
    reg_chk(8'h18, 8'hD2);
    reg_chk(8'h1B, 8'hD0);
    run(32'hD6A5_5A33, 4, 4'h7);
    `CHK("reset count", 1, n_done)
    reg_wr(8'h18, 8'h1E);
    rst_n_pin = 1'b0;
    repeat (4) @(negedge mclk);
    reg_chk(8'h18, 8'hD2);
    reg_wr(8'h18, 8'h1E);
    reg_chk(8'h18, 8'hD2);
    rst_n_pin = 1'b1;
    repeat (4) @(negedge mclk);
    reg_wr(8'h18, 8'h1E);
    reg_chk(8'h18, 8'hDE);
    repeat (200) @(negedge mclk);
    `CHK("led_on", 2'b01, led[1:0])
    final_report();
  end
endmodule : tb
`default_nettype wire
